// ### design/audio_clk_defines.vh
// constants for the serial clock configuration and monitor block
// assumes a byte-wide control port with 8-bit register offsets
`ifndef AUDIO_CLK_DEFINES_VH
`define AUDIO_CLK_DEFINES_VH

// register offsets on the control port
`define ADDR_MASTER_MODE     8'h13
`define ADDR_RATE_RATIO      8'h14
`define ADDR_MONITOR_STATUS  8'h15
`define ADDR_CLOCK_SOURCE    8'h16

// reset values
`define RST_MASTER_MODE      8'h02
`define RST_RATE_RATIO       8'h48
`define RST_MONITOR_STATUS   8'hFF
`define RST_CLOCK_SOURCE     8'h10

// master_mode_config fields
`define ROLE_BIT             7
`define AUTO_OFF_BIT         6
`define PLL_OFF_BIT          5
`define GATE_BIT             4
`define FAMILY_BIT           3
// audio_clock_source_config fields
`define ROOT_SRC_BIT         7
`define FREQ_MODE_BIT        6
`define CLOCK_SOURCE_WR_MASK 8'hF8

// codes
`define RATE_CODE_MAX        4'h8
`define INVALID_CODE         4'hF

// rate families, lowest member in Hz
`define BASE_48K_HZ          20'h0_1F40
`define BASE_44K_HZ          20'h0_1CB6

// monitor timing
`define CLK_HZ_DEFAULT       20000000
`define FRAME_TIMEOUT_NS     300000
`define PERIOD_TOL_SHIFT     5

`endif

// ### design/pin_sync.v
// three-stage synchroniser with agreement filter and edge pulses
// assumes pin is asynchronous to clk
module pin_sync
(
  input  wire clk,
  input  wire arst_n,
  input  wire pin,
  output reg  level,
  output reg  rise,
  output reg  fall
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level  <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      rise   <= (s2_reg == s3_reg) && s3_reg && !level;
      fall   <= (s2_reg == s3_reg) && !s3_reg && level;
      if (s2_reg == s3_reg)
        level <= s3_reg;
    end
  end

endmodule // pin_sync

// ### design/bit_clock_nco.v
// phase accumulator giving toggle ticks at step per second of clk
// assumes clk runs at CLK_HZ; steps at or above CLK_HZ tick every cycle
`include "audio_clk_defines.vh"

module bit_clock_nco
#(
  parameter CLK_HZ = `CLK_HZ_DEFAULT,
  parameter STEP_W = 34
)
(
  input  wire              clk,
  input  wire              arst_n,
  input  wire              enable,
  input  wire [STEP_W-1:0] step,
  output reg               tick
);

  localparam [STEP_W-1:0] MODULUS = CLK_HZ;

  reg  [STEP_W-1:0] acc_reg;
  wire [STEP_W:0]   sum = {1'b0, acc_reg} + {1'b0, step};

  // average rate exact, jitter of one clk is the price
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_reg <= {STEP_W{1'b0}};
      tick    <= 1'b0;
    end
    else if (!enable)
    begin
      acc_reg <= {STEP_W{1'b0}};
      tick    <= 1'b0;
    end
    else if (step >= MODULUS)
    begin
      acc_reg <= {STEP_W{1'b0}};
      tick    <= 1'b1;
    end
    else if (sum >= {1'b0, MODULUS})
    begin
      acc_reg <= sum[STEP_W-1:0] - MODULUS;
      tick    <= 1'b1;
    end
    else
    begin
      acc_reg <= sum[STEP_W-1:0];
      tick    <= 1'b0;
    end
  end

endmodule // bit_clock_nco

// ### design/audio_serial_clock_config_monitor.v
// serial audio clock configuration, generation and monitor
// assumes a synchronous byte register port; bit clock and frame sync pins
// are two-way and resolved outside from the enables
//
// Overview of operation
// - rate field codes 0..8 pick 8 to 768 kHz, 9..15 reserved, reset 4
// - programmed rate and ratio ignored in slave automatic configuration
// - ratio codes 0..12 give 16..2048 bits, 14 gives 144, reset 8
// - measured frame rate reported as rate code, 15 invalid, reset 15
// - measured bits per frame reported as ratio code, 15 invalid
// - slave auto without pll: root is bit clock at 0, master clock at 1
// - master clock mode in automatic configuration: 0 fixed frequency field, 1 ratio of frame rate; fixed when automatic is off
// - master clock ratio codes 0..7 give 64..2304, reset code 2
// - monitor status is read-only and resets to all ones
// - family bit picks 48 kHz or 44.1 kHz multiples in master mode
// - role 0 other party drives clocks, role 1 device drives both
// - pll-off bit disables the pll within automatic configuration
// - fixed select picks one of eight master clock inputs 12 to 24.576 MHz
`include "audio_clk_defines.vh"

module audio_serial_clock_config_monitor
#(
  parameter CLK_HZ         = `CLK_HZ_DEFAULT,
  parameter TIMEOUT_CYCLES = `FRAME_TIMEOUT_NS / (1000000000 / `CLK_HZ_DEFAULT)
)
(
  input  wire        clk,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        bit_clock_in,
  output reg         bit_clock_out,
  output reg         bit_clock_oe,
  input  wire        frame_sync_in,
  output reg         frame_sync_out,
  output reg         frame_sync_oe,
  output reg  [3:0]  active_rate_code,
  output reg  [3:0]  active_ratio_code,
  output reg         root_from_master_clock,
  output reg         pll_enabled,
  output reg         master_clock_by_ratio,
  output reg  [14:0] master_clock_fixed_khz,
  output reg  [11:0] master_clock_ratio
);

  // rate code to multiple of the family base
  function [7:0] rate_mult;
    input [3:0] code;
    begin
      case (code)
        4'h0:    rate_mult = 8'h01;
        4'h1:    rate_mult = 8'h02;
        4'h2:    rate_mult = 8'h03;
        4'h3:    rate_mult = 8'h04;
        4'h4:    rate_mult = 8'h06;
        4'h5:    rate_mult = 8'h0C;
        4'h6:    rate_mult = 8'h18;
        4'h7:    rate_mult = 8'h30;
        4'h8:    rate_mult = 8'h60;
        default: rate_mult = 8'h00;
      endcase
    end
  endfunction

  // ratio code to bits per frame, zero when reserved
  function [11:0] ratio_bits;
    input [3:0] code;
    begin
      case (code)
        4'h0:    ratio_bits = 12'h010;
        4'h1:    ratio_bits = 12'h018;
        4'h2:    ratio_bits = 12'h020;
        4'h3:    ratio_bits = 12'h030;
        4'h4:    ratio_bits = 12'h040;
        4'h5:    ratio_bits = 12'h060;
        4'h6:    ratio_bits = 12'h080;
        4'h7:    ratio_bits = 12'h0C0;
        4'h8:    ratio_bits = 12'h100;
        4'h9:    ratio_bits = 12'h180;
        4'hA:    ratio_bits = 12'h200;
        4'hB:    ratio_bits = 12'h400;
        4'hC:    ratio_bits = 12'h800;
        4'hE:    ratio_bits = 12'h090;
        default: ratio_bits = 12'h000;
      endcase
    end
  endfunction

  // control registers
  reg [7:0] master_mode_config;
  reg [7:0] master_rate_ratio_config;
  reg [7:0] serial_clock_monitor_status;
  reg [7:0] audio_clock_source_config;

  wire       role_master  = master_mode_config[`ROLE_BIT];
  wire       auto_on      = !master_mode_config[`AUTO_OFF_BIT];
  wire       pll_off      = master_mode_config[`PLL_OFF_BIT];
  wire       out_gate     = master_mode_config[`GATE_BIT];
  wire       family_44k   = master_mode_config[`FAMILY_BIT];
  wire [3:0] prog_rate    = master_rate_ratio_config[7:4];
  wire [3:0] prog_bits    = master_rate_ratio_config[3:0];
  wire       slave_auto   = !role_master && auto_on;

  // register writes; status has no write path
  // status read-only
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      master_mode_config        <= `RST_MASTER_MODE;
      master_rate_ratio_config  <= `RST_RATE_RATIO;
      audio_clock_source_config <= `RST_CLOCK_SOURCE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_MASTER_MODE:  master_mode_config <= reg_wdata;
        `ADDR_RATE_RATIO:   master_rate_ratio_config <= reg_wdata;
        `ADDR_CLOCK_SOURCE: audio_clock_source_config <= reg_wdata & `CLOCK_SOURCE_WR_MASK;
        default:            master_mode_config <= master_mode_config;
      endcase
    end
  end

  // read data; unmapped offsets read zero
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_MASTER_MODE:    reg_rdata <= master_mode_config;
        `ADDR_RATE_RATIO:     reg_rdata <= master_rate_ratio_config;
        `ADDR_MONITOR_STATUS: reg_rdata <= serial_clock_monitor_status;
        `ADDR_CLOCK_SOURCE:   reg_rdata <= audio_clock_source_config;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // ---- master generation ----
  // rate decode
  wire [7:0]  prog_mult = rate_mult(prog_rate);
  wire [19:0] base_hz   = family_44k ? `BASE_44K_HZ : `BASE_48K_HZ;
  wire [19:0] prog_hz   = base_hz * {12'h000, prog_mult};
  wire [11:0] frame_bits = ratio_bits(prog_bits);
  wire [31:0] bit_hz     = prog_hz * {8'h00, frame_bits};
  reg  [33:0] step_reg;
  reg         gen_en_reg;

  // step is twice the bit rate: one tick per bit clock half
  // generator setup
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_reg   <= 34'h0_0000_0000;
      gen_en_reg <= 1'b0;
    end
    else
    begin
      step_reg   <= {1'b0, bit_hz, 1'b0};
      gen_en_reg <= role_master && (prog_rate <= `RATE_CODE_MAX) && (frame_bits != 12'h000);
    end
  end

  wire half_tick;

  bit_clock_nco #(.CLK_HZ(CLK_HZ), .STEP_W(34)) u_nco
  (
    .clk    (clk),
    .arst_n (arst_n),
    .enable (gen_en_reg),
    .step   (step_reg),
    .tick   (half_tick)
  );

  reg        bclk_int_reg;
  reg        frame_sync_int_reg;
  reg [11:0] bit_idx_reg;

  // frame sync high for the first bit, changes on falling bit clock
  // frame and bit clock
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bclk_int_reg  <= 1'b0;
      frame_sync_int_reg <= 1'b0;
      bit_idx_reg   <= 12'h000;
    end
    else if (!gen_en_reg)
    begin
      bclk_int_reg  <= 1'b0;
      frame_sync_int_reg <= 1'b0;
      bit_idx_reg   <= 12'h000;
    end
    else if (half_tick)
    begin
      bclk_int_reg <= !bclk_int_reg;
      if (bclk_int_reg)
      begin
        if (bit_idx_reg >= frame_bits - 12'h001)
        begin
          bit_idx_reg   <= 12'h000;
          frame_sync_int_reg <= 1'b1;
        end
        else
        begin
          bit_idx_reg   <= bit_idx_reg + 12'h001;
          frame_sync_int_reg <= 1'b0;
        end
      end
    end
  end

  // pin drive; gate holds both low while the enables stay on
  // role selects driver
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_clock_out  <= 1'b0;
      bit_clock_oe   <= 1'b0;
      frame_sync_out <= 1'b0;
      frame_sync_oe  <= 1'b0;
    end
    else
    begin
      bit_clock_out  <= bclk_int_reg && !out_gate;
      frame_sync_out <= frame_sync_int_reg && !out_gate;
      bit_clock_oe   <= role_master;
      frame_sync_oe  <= role_master;
    end
  end

  // ---- monitor ----
  wire bclk_rise;
  wire frame_sync_rise;

  pin_sync u_bclk_sync
  (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (bit_clock_in),
    .level  (),
    .rise   (bclk_rise),
    .fall   ()
  );

  pin_sync u_frame_sync_sync
  (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (frame_sync_in),
    .level  (),
    .rise   (frame_sync_rise),
    .fall   ()
  );

  reg [15:0] period_cnt_reg;
  reg [11:0] bits_cnt_reg;
  reg        seen_frame_reg;
  reg [3:0]  det_rate;
  reg [3:0]  det_ratio;
  integer    i;
  integer    p48;
  integer    p44;
  integer    per;

  // nearest code within 1/32 of nominal period, else invalid
  // rate classification
  always @*
  begin
    det_rate  = `INVALID_CODE;
    det_ratio = `INVALID_CODE;
    per       = period_cnt_reg;
    p48       = 0;
    p44       = 0;
    for (i = 0; i <= 8; i = i + 1)
    begin
      p48 = CLK_HZ / (`BASE_48K_HZ * rate_mult(i[3:0]));
      p44 = CLK_HZ / (`BASE_44K_HZ * rate_mult(i[3:0]));
      if ((per > p48 - (p48 >> `PERIOD_TOL_SHIFT)) && (per < p48 + (p48 >> `PERIOD_TOL_SHIFT)))
        det_rate = i[3:0];
      if ((per > p44 - (p44 >> `PERIOD_TOL_SHIFT)) && (per < p44 + (p44 >> `PERIOD_TOL_SHIFT)))
        det_rate = i[3:0];
    end
    for (i = 0; i <= 14; i = i + 1)
    begin
      if ((ratio_bits(i[3:0]) != 12'h000) && (ratio_bits(i[3:0]) == bits_cnt_reg))
        det_ratio = i[3:0];
    end
  end

  // counts span one frame; a silent bus times out to invalid
  // rate status update
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      period_cnt_reg              <= 16'h0000;
      bits_cnt_reg                <= 12'h000;
      seen_frame_reg              <= 1'b0;
      serial_clock_monitor_status <= `RST_MONITOR_STATUS;
    end
    else if (frame_sync_rise)
    begin
      period_cnt_reg <= 16'h0001;
      bits_cnt_reg   <= bclk_rise ? 12'h001 : 12'h000;
      seen_frame_reg <= 1'b1;
      if (seen_frame_reg)
        serial_clock_monitor_status <= {det_rate, det_ratio};
    end
    else if (period_cnt_reg >= TIMEOUT_CYCLES[15:0])
    begin
      seen_frame_reg              <= 1'b0;
      serial_clock_monitor_status <= `RST_MONITOR_STATUS;
    end
    else
    begin
      period_cnt_reg <= period_cnt_reg + 16'h0001;
      if (bclk_rise && (bits_cnt_reg != 12'hFFF))
        bits_cnt_reg <= bits_cnt_reg + 12'h001;
    end
  end

  // effective clock tree settings
  // slave auto uses detected
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_rate_code       <= 4'h4;
      active_ratio_code      <= 4'h8;
      root_from_master_clock <= 1'b0;
      pll_enabled            <= 1'b1;
      master_clock_by_ratio  <= 1'b0;
      master_clock_fixed_khz <= 15'h32C8;
      master_clock_ratio     <= 12'h180;
    end
    else
    begin
      active_rate_code       <= slave_auto ? serial_clock_monitor_status[7:4] : prog_rate;
      active_ratio_code      <= slave_auto ? serial_clock_monitor_status[3:0] : prog_bits;
      root_from_master_clock <= slave_auto && pll_off && audio_clock_source_config[`ROOT_SRC_BIT];
      pll_enabled            <= !(auto_on && pll_off);
      master_clock_by_ratio  <= auto_on && audio_clock_source_config[`FREQ_MODE_BIT];
      case (master_mode_config[2:0])
        3'h0:    master_clock_fixed_khz <= 15'h2EE0;
        3'h1:    master_clock_fixed_khz <= 15'h3000;
        3'h2:    master_clock_fixed_khz <= 15'h32C8;
        3'h3:    master_clock_fixed_khz <= 15'h3E80;
        3'h4:    master_clock_fixed_khz <= 15'h4B00;
        3'h5:    master_clock_fixed_khz <= 15'h4CE0;
        3'h6:    master_clock_fixed_khz <= 15'h5DC0;
        default: master_clock_fixed_khz <= 15'h6000;
      endcase
      case (audio_clock_source_config[5:3])
        3'h0:    master_clock_ratio <= 12'h040;
        3'h1:    master_clock_ratio <= 12'h100;
        3'h2:    master_clock_ratio <= 12'h180;
        3'h3:    master_clock_ratio <= 12'h200;
        3'h4:    master_clock_ratio <= 12'h300;
        3'h5:    master_clock_ratio <= 12'h400;
        3'h6:    master_clock_ratio <= 12'h600;
        default: master_clock_ratio <= 12'h900;
      endcase
    end
  end

endmodule // audio_serial_clock_config_monitor

// ### testbench/audio_clk_checker_sva.sv
// assertions on the top ports of the serial clock block
// assumes pins are resolved outside the block
module audio_clk_checker
(
  input logic        clk,
  input logic        arst_n,
  input logic [7:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [7:0]  reg_rdata,
  input logic        bit_clock_out,
  input logic        bit_clock_oe,
  input logic        frame_sync_out,
  input logic        frame_sync_oe,
  input logic [3:0]  active_ratio_code,
  input logic        root_from_master_clock,
  input logic        pll_enabled,
  input logic [14:0] master_clock_fixed_khz,
  input logic [11:0] master_clock_ratio
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  int bits_tab [16] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024, 2048, 0, 144, 0};
  logic       fs_q;
  logic       bc_q;
  logic       armed;
  logic [11:0] cnt;

  // bit clock rises per frame; first frame only arms, a partial one is likely
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      fs_q <= 1'b0;
      bc_q <= 1'b0;
      armed <= 1'b0;
      cnt <= 12'h000;
    end
    else
    begin
      fs_q <= frame_sync_out;
      bc_q <= bit_clock_out;
      if (!bit_clock_oe)
      begin
        armed <= 1'b0;
        cnt <= 12'h000;
      end
      else if (frame_sync_out && !fs_q)
      begin
        armed <= 1'b1;
        cnt <= 12'h000;
      end
      else if (bit_clock_out && !bc_q)
        cnt <= cnt + 12'h001;
    end

  sequence role_wr;
    reg_wr && reg_addr == 8'h13 && reg_wdata[7];
  endsequence
  sequence fs_rise;
    armed && frame_sync_out && !fs_q;
  endsequence

  oe_pair_a: assert property (frame_sync_oe == bit_clock_oe)
    else $error("clock enables differ");
  role_drive_a: assert property (role_wr |-> ##[1:2] bit_clock_oe)
    else $error("master role does not drive pins");
  frame_len_a: assert property (fs_rise |-> cnt == bits_tab[active_ratio_code])
    else $error("frame length wrong");
  pll_off_a: assert property (reg_wr && reg_addr == 8'h13 && reg_wdata[6:5] == 2'b01
    |-> ##[1:2] !pll_enabled)
    else $error("pll still enabled");
  root_cond_a: assert property (root_from_master_clock |-> !pll_enabled && !bit_clock_oe)
    else $error("root source outside slave pll-off");
  fixed_sel_a: assert property (reg_wr && reg_addr == 8'h13 && reg_wdata[2:0] == 3'h7
    |-> ##[1:2] master_clock_fixed_khz == 15'h6000)
    else $error("fixed frequency decode wrong");
  mclk_ratio_a: assert property (reg_wr && reg_addr == 8'h16 && reg_wdata[5:3] == 3'h0
    |-> ##[1:2] master_clock_ratio == 12'h040)
    else $error("master clock ratio decode wrong");
  rsvd_zero_a: assert property (reg_rd && reg_addr == 8'h16 |-> ##1 reg_rdata[2:0] == 3'h0)
    else $error("reserved bits not zero");
endmodule // audio_clk_checker

bind audio_serial_clock_config_monitor audio_clk_checker u_chk (.clk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .bit_clock_out, .bit_clock_oe, .frame_sync_out, .frame_sync_oe,
  .active_ratio_code, .root_from_master_clock, .pll_enabled, .master_clock_fixed_khz, .master_clock_ratio);

// ### testbench/host_link_model.sv
// host processor side of the serial bus in slave role
// assumes a 400 ns bit clock; both lines stand still low between bursts
module host_link_model
(
  input  logic run,
  input  int   bits,
  output logic bclk,
  output logic frame_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  int len;

  // whole frames only, so the monitor never sees a cut frame;
  // length latched at frame start so a new setting never stretches one
  initial
  begin
    bclk = 1'b0;
    frame_sync = 1'b0;
    forever
    begin
      wait (run);
      len = bits;
      for (int b = 0; b < len; b++)
      begin
        frame_sync = (b == 0);
        #200 bclk = 1'b1;
        #200 bclk = 1'b0;
      end
      frame_sync = 1'b0;
    end
  end
endmodule // host_link_model

// ### testbench/tb_audio_serial_clock_config_monitor.sv
// self-checking bench for the serial clock configuration block
// assumes 20 MHz clk and the host model on the two clock pins
module tb_audio_serial_clock_config_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, arst_n, reg_wr, reg_rd, run;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        bco, bcoe, fso, fsoe, hb, hf, root, pll, byr;
  logic [3:0]  rate_c, ratio_c;
  logic [14:0] fkhz;
  logic [11:0] mratio;
  int          bits = 16;
  int          failures = 0;
  int          compares = 0;
  wire         bc_pin = bcoe ? bco : hb;
  wire         fs_pin = fsoe ? fso : hf;

  audio_serial_clock_config_monitor #(.TIMEOUT_CYCLES(2000)) u_dut (.clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .bit_clock_in(bc_pin), .bit_clock_out(bco), .bit_clock_oe(bcoe),
    .frame_sync_in(fs_pin), .frame_sync_out(fso), .frame_sync_oe(fsoe), .active_rate_code(rate_c),
    .active_ratio_code(ratio_c), .root_from_master_clock(root), .pll_enabled(pll),
    .master_clock_by_ratio(byr), .master_clock_fixed_khz(fkhz), .master_clock_ratio(mratio));
  host_link_model u_host (.run(run), .bits(bits), .bclk(hb), .frame_sync(hf));

  task automatic bad(input int g, e);
    failures++;
    $display("BAD t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic cmp8(input logic [7:0] g, e);
    compares++;
    if (g !== e)
      bad(g, e);
  endtask
  task automatic cmp16(input logic [15:0] g, e);
    compares++;
    if (g !== e)
      bad(g, e);
  endtask
  task automatic cmp_rng(input int g, lo, hi);
    compares++;
    if (g < lo || g > hi)
      bad(g, lo);
  endtask
  // control port cycles, inputs move at the falling edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    cmp8(reg_rdata, e);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  // bounded wait for the next frame sync rise
  task automatic fs_edge(output int n);
    n = 0;
    while (fso === 1'b1 && n < 6000)
    begin
      @(negedge clk);
      n++;
    end
    while (fso !== 1'b1 && n < 6000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic t_regs;
    rd_chk(8'h13, 8'h02);
    rd_chk(8'h14, 8'h48);
    rd_chk(8'h15, 8'hff);
    rd_chk(8'h16, 8'h10);
    wr(8'h16, 8'hff);
    rd_chk(8'h16, 8'hf8);
    wr(8'h15, 8'h00);
    rd_chk(8'h15, 8'hff);
    wr(8'h14, 8'he3);
    rd_chk(8'h14, 8'he3);
    rd_chk(8'h20, 8'h00);
    $display("done regs");
  endtask
  task automatic t_decode;
    logic [15:0] khz [8] = '{16'h2ee0, 16'h3000, 16'h32c8, 16'h3e80, 16'h4b00, 16'h4ce0, 16'h5dc0, 16'h6000};
    logic [15:0] rat [8] = '{16'h0040, 16'h0100, 16'h0180, 16'h0200, 16'h0300, 16'h0400, 16'h0600, 16'h0900};
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h13, 8'(i));
      wr(8'h16, 8'(i << 3));
      settle;
      cmp16({1'b0, fkhz}, khz[i]);
      cmp16({4'h0, mratio}, rat[i]);
    end
    wr(8'h13, 8'h20);
    wr(8'h16, 8'hd0);
    settle;
    cmp8({5'h00, pll, root, byr}, 8'h03);
    wr(8'h13, 8'h60);
    settle;
    cmp8({5'h00, pll, root, byr}, 8'h04);
    wr(8'h16, 8'h10);
    wr(8'h13, 8'h20);
    settle;
    cmp8({5'h00, pll, root, byr}, 8'h00);
    $display("done decode");
  endtask
  // slave auto: programmed codes must not show, detected codes do
  task automatic t_slave(input int b, input logic [7:0] e);
    wr(8'h13, 8'h02);
    bits = b;
    run = 1'b1;
    repeat (32 * b + 40) @(negedge clk);
    cmp8({rate_c, ratio_c}, e);
    rd_chk(8'h15, e);
    run = 1'b0;
    $display("done slave %0d", b);
  endtask
  task automatic t_timeout;
    repeat (3400) @(negedge clk);
    rd_chk(8'h15, 8'hff);
    cmp8({rate_c, ratio_c}, 8'hff);
    $display("done timeout");
  endtask
  task automatic t_master(input logic [7:0] mode, input int per);
    int n;
    wr(8'h14, 8'h00);
    wr(8'h13, mode);
    settle;
    cmp8({rate_c, ratio_c}, 8'h00);
    cmp8({6'h00, fsoe, bcoe}, 8'h03);
    fs_edge(n);
    fs_edge(n);
    fs_edge(n);
    cmp_rng(n, per - 3, per + 3);
    wr(8'h13, 8'h02);
    $display("done master %h", mode);
  endtask

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // bench clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    run = 1'b0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    t_regs;
    t_decode;
    t_slave(64, 8'hf4);
    t_slave(144, 8'hfe);
    t_slave(78, 8'h3f);
    t_timeout;
    t_master(8'h80, 2500);
    t_master(8'h88, 2721);
    test_done;
  end
  // watchdog, nearly three times the expected run
  initial
  begin
    #4ms;
    failures++;
    test_done;
  end
endmodule // tb_audio_serial_clock_config_monitor
